// [core/pgw_page_write_guard.sv]
// command decoder: channel paging, broadcast masking, write protection
// assumes an upstream serial slave that hands over one decoded command per strobe
`default_nettype none
`include "pgw_regs.svh"
module pgw_page_write_guard
    import pgw_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rstn,
    // decoded command port
    input  wire pgw_cmd_s  cmd,
    output pgw_rsp_s       rsp,
    // write-protect pin, asynchronous
    input  wire logic      wp_pin,
    // nonvolatile copy of the protection byte
    input  wire logic      nv_wp_load,
    input  wire logic [7:0] nv_wp_value,
    output logic [7:0]     wp_setting,
    // channel writes
    output pgw_chwr_s      chwr,
    // fault record store
    output logic           log_restore,
    output logic           log_clear,
    output logic [7:0]     log_addr,
    input  wire logic [7:0] log_byte,
    input  wire logic [7:0] log_state,
    // status and telemetry
    input  wire logic [7:0] family_flags,
    input  wire pgw_tel_s  tel,
    // settings and flags
    output logic [7:0]     retry_limit,
    output logic [7:0]     bcast_mask,
    output logic [7:0]     channel_select,
    output logic           cml_fault
);

    typedef struct packed {
        logic       wp_s1;
        logic       wp_s2;
        logic [7:0] page;
        logic [7:0] wp_byte;
        logic [7:0] mask;
        logic [7:0] retry;
        logic [7:0] blk_left;
        logic [7:0] log_addr;
        logic       cml;
        logic       log_restore;
        logic       log_clear;
        pgw_rsp_s   rsp;
        pgw_chwr_s  chwr;
    } pgw_st_s;

    localparam pgw_rsp_s RSP_IDLE = '{ack: 1'b0, err: 1'b0, fmt: PGW_FMT_REG,
                                      data: 16'h0000};
    localparam pgw_st_s ST_RST = '{wp_s1: 1'b0, wp_s2: 1'b0, page: `PGW_PAGE_RST,
                                   wp_byte: `PGW_WP_RST, mask: `PGW_MASK_RST,
                                   retry: `PGW_RETRY_RST, blk_left: 8'h00,
                                   log_addr: 8'h00, cml: 1'b0, log_restore: 1'b0,
                                   log_clear: 1'b0, rsp: RSP_IDLE, chwr: '0};

    pgw_st_s  st;
    pgw_st_s  next_st;
    pgw_lvl_e level;
    logic     permit;
    logic     is_wr;
    logic     bcast;
    logic     chan_ok;
    logic     paged;
    logic     set_cml;
    logic     clr_cml;

    pgw_wp_guard u_wp_guard (
        .wp_byte      (st.wp_byte),
        .wp_pin_level (st.wp_s2),
        .code         (cmd.code),
        .level        (level),
        .permit       (permit)
    );

    assign is_wr   = (cmd.kind == PGW_SEND) || (cmd.kind == PGW_WR_BYTE) ||
                     (cmd.kind == PGW_WR_WORD);
    assign bcast   = (st.page == `PGW_PAGE_BCAST);
    assign chan_ok = (st.page <= `PGW_PAGE_LAST);
    assign paged   = pgw_is_paged(cmd.code);

    always_comb begin
        next_st             = st;
        set_cml             = 1'b0;
        clr_cml             = 1'b0;
        // first stage feeds only the second
        next_st.wp_s1       = wp_pin;
        next_st.wp_s2       = st.wp_s1;
        next_st.rsp         = RSP_IDLE;
        next_st.chwr.valid  = 1'b0;
        next_st.log_restore = 1'b0;
        next_st.log_clear   = 1'b0;
        if (nv_wp_load) begin
            next_st.wp_byte = nv_wp_value;
        end
        if (cmd.valid) begin
            next_st.rsp.ack = 1'b1;
            if (is_wr) begin
                if (!permit) begin
                    next_st.rsp.err = 1'b1;
                    set_cml         = 1'b1;
                end else if (bcast && paged && !pgw_is_bcastable(cmd.code)) begin
                    next_st.rsp.err = 1'b1;
                    set_cml         = 1'b1;
                end else begin
                    case (cmd.code)
                        `PGW_CMD_PAGE: begin
                            next_st.page = cmd.data[7:0];
                        end
                        `PGW_CMD_WP: begin
                            next_st.wp_byte = cmd.data[7:0];
                        end
                        `PGW_CMD_MASK: begin
                            next_st.mask = cmd.data[7:0];
                        end
                        `PGW_CMD_RETRY: begin
                            next_st.retry = cmd.data[7:0];
                        end
                        `PGW_CMD_LOG_RESTORE: begin
                            next_st.log_restore = 1'b1;
                        end
                        `PGW_CMD_LOG_CLEAR: begin
                            next_st.log_clear = 1'b1;
                        end
                        `PGW_CMD_LOG_STATE, `PGW_CMD_LOG_STREAM, `PGW_CMD_FAMILY,
                        `PGW_CMD_VOUT_MIN, `PGW_CMD_VIN_MIN, `PGW_CMD_TEMP_MIN: begin
                            // read-only codes refuse writes
                            next_st.rsp.err = 1'b1;
                            set_cml         = 1'b1;
                        end
                        default: begin
                            next_st.chwr.valid = 1'b1;
                            next_st.chwr.code  = cmd.code;
                            next_st.chwr.data  = cmd.data;
                            if (!paged) begin
                                next_st.chwr.mask = 8'h00;
                            end else if (bcast) begin
                                next_st.chwr.mask = st.mask;
                            end else if (chan_ok) begin
                                next_st.chwr.mask = 8'h01 << st.page[2:0];
                            end else begin
                                next_st.chwr.mask = 8'h00;
                            end
                            if (cmd.code == `PGW_CMD_CLEAR) begin
                                clr_cml = 1'b1;
                            end
                        end
                    endcase
                end
            end else if (bcast && paged) begin
                next_st.rsp.err = 1'b1;
                set_cml         = 1'b1;
            end else begin
                case (cmd.code)
                    `PGW_CMD_PAGE:  next_st.rsp.data = {8'h00, st.page};
                    `PGW_CMD_WP:    next_st.rsp.data = {8'h00, st.wp_byte};
                    `PGW_CMD_MASK:  next_st.rsp.data = {8'h00, st.mask};
                    `PGW_CMD_RETRY: next_st.rsp.data = {8'h00, st.retry};
                    `PGW_CMD_LOG_STATE: next_st.rsp.data = {8'h00, log_state};
                    `PGW_CMD_FAMILY: next_st.rsp.data = {8'h00, family_flags};
                    `PGW_CMD_VOUT_MIN: begin
                        next_st.rsp.fmt = PGW_FMT_UV;
                        if (chan_ok) begin
                            next_st.rsp.data = tel.vout_min[st.page[2:0]];
                        end else begin
                            next_st.rsp.err = 1'b1;
                        end
                    end
                    `PGW_CMD_VIN_MIN: begin
                        next_st.rsp.fmt  = PGW_FMT_SL;
                        next_st.rsp.data = tel.vin_min;
                    end
                    `PGW_CMD_TEMP_MIN: begin
                        next_st.rsp.fmt  = PGW_FMT_SL;
                        next_st.rsp.data = tel.temp_min;
                    end
                    `PGW_CMD_LOG_STREAM: begin
                        if (cmd.kind == PGW_RD_BLK_FIRST) begin
                            next_st.rsp.data = `PGW_LOG_LEAD;
                            next_st.blk_left = `PGW_LOG_DATA_LEN;
                            next_st.log_addr = 8'h00;
                        end else if (cmd.kind == PGW_RD_BLK_NEXT && st.blk_left != 8'h00) begin
                            next_st.rsp.data = {8'h00, log_byte};
                            next_st.blk_left = st.blk_left - 8'h01;
                            next_st.log_addr = st.log_addr + 8'h01;
                        end else begin
                            next_st.rsp.err = 1'b1;
                        end
                    end
                    default: begin
                        next_st.rsp.err = 1'b1;
                    end
                endcase
            end
        end
        // set wins over clear
        next_st.cml = set_cml | (st.cml & ~clr_cml);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rsp            = st.rsp;
    assign chwr           = st.chwr;
    assign wp_setting     = st.wp_byte;
    assign log_restore    = st.log_restore;
    assign log_clear      = st.log_clear;
    assign log_addr       = st.log_addr;
    assign retry_limit    = st.retry;
    assign bcast_mask     = st.mask;
    assign channel_select = st.page;
    assign cml_fault      = st.cml;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_single_chan;
        cmd.valid && is_wr && permit && cmd.code == `PGW_CMD_OPERATION && chan_ok
        |=> chwr.valid && chwr.mask == (8'h01 << $past(st.page[2:0]));
    endproperty
    a_single_chan: assert property (p_single_chan) else $error("page not routed");

    property p_bcast_mask;
        cmd.valid && is_wr && permit && bcast && pgw_is_bcastable(cmd.code)
        |=> chwr.valid && chwr.mask == $past(st.mask);
    endproperty
    a_bcast_mask: assert property (p_bcast_mask) else $error("broadcast mask wrong");

    property p_bcast_read;
        cmd.valid && !is_wr && bcast && paged |=> rsp.err && cml_fault;
    endproperty
    a_bcast_read: assert property (p_bcast_read) else $error("broadcast read unflagged");

    property p_bcast_bad_wr;
        cmd.valid && is_wr && permit && bcast && paged && !pgw_is_bcastable(cmd.code)
        |=> !chwr.valid && cml_fault && rsp.err;
    endproperty
    a_bcast_bad_wr: assert property (p_bcast_bad_wr) else $error("illegal broadcast kept");

    property p_l1_block;
        cmd.valid && is_wr && level == PGW_LVL_1 && cmd.code == `PGW_CMD_OPERATION
        |=> rsp.err && !chwr.valid && cml_fault;
    endproperty
    a_l1_block: assert property (p_l1_block) else $error("level one let write in");

    property p_l2_retry;
        cmd.valid && is_wr && level == PGW_LVL_2 && cmd.code == `PGW_CMD_RETRY
        |=> $stable(retry_limit) && rsp.err && cml_fault;
    endproperty
    a_l2_retry: assert property (p_l2_retry) else $error("level two let retry in");

    property p_pin_level;
        st.wp_s2 && st.wp_byte == `PGW_WP_NONE_CODE |-> level == PGW_LVL_2;
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin did not force level two");

    property p_lead_byte;
        cmd.valid && cmd.kind == PGW_RD_BLK_FIRST && cmd.code == `PGW_CMD_LOG_STREAM && !bcast
        |=> rsp.data == `PGW_LOG_LEAD && !rsp.err;
    endproperty
    a_lead_byte: assert property (p_lead_byte) else $error("block lead byte wrong");

    property p_retry_wr;
        cmd.valid && is_wr && permit && cmd.code == `PGW_CMD_RETRY
        |=> retry_limit == $past(cmd.data[7:0]) && !rsp.err;
    endproperty
    a_retry_wr: assert property (p_retry_wr) else $error("retry count not stored");

    property p_vin_read;
        cmd.valid && !is_wr && cmd.code == `PGW_CMD_VIN_MIN
        |=> rsp.ack && !rsp.err && rsp.fmt == PGW_FMT_SL && rsp.data == $past(tel.vin_min);
    endproperty
    a_vin_read: assert property (p_vin_read) else $error("input minimum read failed");

    property p_restore;
        cmd.valid && is_wr && permit && cmd.code == `PGW_CMD_LOG_RESTORE
        |=> log_restore && !log_clear && rsp.ack && !rsp.err;
    endproperty
    a_restore: assert property (p_restore) else $error("restore strobe missing");

    c_bcast_ok: cover property (cmd.valid && is_wr && bcast && permit ##1 chwr.valid);
    c_block: cover property (cmd.valid && cmd.kind == PGW_RD_BLK_FIRST ##2
                             cmd.valid && cmd.kind == PGW_RD_BLK_NEXT);
    c_reject: cover property (cmd.valid && is_wr && !permit ##1 rsp.err);
    c_bread: cover property (cmd.valid && !is_wr && bcast && paged);

endmodule
`default_nettype wire

// [core/pgw_pkg.sv]
// types shared by the page and write guard core and its level checker
// assumes pgw_regs.svh is on the include path
`default_nettype none
`include "pgw_regs.svh"
package pgw_pkg;

    typedef enum logic [2:0] {
        PGW_SEND, PGW_WR_BYTE, PGW_WR_WORD, PGW_RD_BYTE, PGW_RD_WORD,
        PGW_RD_BLK_FIRST, PGW_RD_BLK_NEXT
    } pgw_kind_e;

    typedef enum logic [1:0] {PGW_FMT_REG, PGW_FMT_SL, PGW_FMT_UV} pgw_fmt_e;

    typedef enum logic [1:0] {PGW_LVL_NONE, PGW_LVL_2, PGW_LVL_1} pgw_lvl_e;

    // short linear word: exponent in the top five bits, mantissa below
    typedef struct packed {
        logic signed [4:0]  exp;
        logic signed [10:0] man;
    } pgw_sl_s;

    typedef struct packed {
        logic       valid;
        pgw_kind_e  kind;
        logic [7:0] code;
        logic [15:0] data;
    } pgw_cmd_s;

    typedef struct packed {
        logic        ack;
        logic        err;
        pgw_fmt_e    fmt;
        logic [15:0] data;
    } pgw_rsp_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  mask;
        logic [7:0]  code;
        logic [15:0] data;
    } pgw_chwr_s;

    typedef struct packed {
        logic [7:0][15:0] vout_min;
        pgw_sl_s          vin_min;
        pgw_sl_s          temp_min;
    } pgw_tel_s;

    function automatic logic pgw_is_paged(input logic [7:0] code);
        case (code)
            `PGW_CMD_OPERATION, `PGW_CMD_ON_OFF, `PGW_CMD_CLEAR, `PGW_CMD_VOUT_MIN,
            8'hd2, 8'hd3, 8'hdd, 8'he0, 8'he8, 8'he9: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    function automatic logic pgw_is_bcastable(input logic [7:0] code);
        return (code == `PGW_CMD_CLEAR) || (code == `PGW_CMD_OPERATION) ||
               (code == `PGW_CMD_ON_OFF);
    endfunction

endpackage
`default_nettype wire

// [core/pgw_regs.svh]
// command codes, field layouts, reset values for the page and write guard
// assumes inclusion by bare name from the package and the core files
`ifndef PGW_REGS_SVH
`define PGW_REGS_SVH

`define PGW_CMD_PAGE         8'h00
`define PGW_CMD_OPERATION    8'h01
`define PGW_CMD_ON_OFF       8'h02
`define PGW_CMD_CLEAR        8'h03
`define PGW_CMD_WP           8'h10
`define PGW_CMD_STORE_ALL    8'h15
`define PGW_CMD_NV_UNLOCK    8'hbd
`define PGW_CMD_MASK         8'he4
`define PGW_CMD_LOG_RESTORE  8'heb
`define PGW_CMD_LOG_CLEAR    8'hec
`define PGW_CMD_LOG_STATE    8'hed
`define PGW_CMD_LOG_STREAM   8'hee
`define PGW_CMD_FAMILY       8'hef
`define PGW_CMD_RETRY        8'hf7
`define PGW_CMD_VOUT_MIN     8'hfb
`define PGW_CMD_VIN_MIN      8'hfc
`define PGW_CMD_TEMP_MIN     8'hfd

`define PGW_PAGE_LAST        8'h07
`define PGW_PAGE_BCAST       8'hff
`define PGW_WP_L1_CODE       8'h80
`define PGW_WP_L2_CODE       8'h40
`define PGW_WP_NONE_CODE     8'h00

`define PGW_PAGE_RST         8'h00
`define PGW_WP_RST           8'h00
`define PGW_MASK_RST         8'hff
`define PGW_RETRY_RST        8'h07

`define PGW_LOG_LEAD         16'h00ff
`define PGW_LOG_DATA_LEN     8'hff

`define PGW_SL_EXP_MSB       15
`define PGW_SL_EXP_LSB       11
`define PGW_SL_MAN_MSB       10
`define PGW_UV_EXP           5'h13

`endif

// [core/pgw_wp_guard.sv]
// effective write-protect level and per-command write permission
// assumes a synchronised pin level and the stored protection byte
`default_nettype none
`include "pgw_regs.svh"
module pgw_wp_guard
    import pgw_pkg::*;
(
    // protection sources
    input  wire logic [7:0] wp_byte,
    input  wire logic       wp_pin_level,
    // command under test
    input  wire logic [7:0] code,
    // verdict
    output pgw_lvl_e        level,
    output logic            permit
);

    pgw_lvl_e byte_level;
    logic     l1_ok;
    logic     l2_ok;

    always_comb begin
        case (wp_byte)
            `PGW_WP_L1_CODE: byte_level = PGW_LVL_1;
            `PGW_WP_L2_CODE: byte_level = PGW_LVL_2;
            default:         byte_level = PGW_LVL_NONE;
        endcase
        if (wp_pin_level && byte_level == PGW_LVL_NONE) begin
            level = PGW_LVL_2;
        end else begin
            level = byte_level;
        end
        l1_ok = (code == `PGW_CMD_WP) || (code == `PGW_CMD_PAGE) ||
                (code == `PGW_CMD_NV_UNLOCK) || (code == `PGW_CMD_STORE_ALL);
        l2_ok = l1_ok || (code == `PGW_CMD_OPERATION) || (code == `PGW_CMD_MASK) ||
                (code == `PGW_CMD_CLEAR);
        case (level)
            PGW_LVL_1: permit = l1_ok;
            PGW_LVL_2: permit = l2_ok;
            default:   permit = 1'b1;
        endcase
    end

endmodule
`default_nettype wire

// [verification/pgw_host_model.sv]
// host-side model: issues one decoded command and collects the answer
// assumes the guard answers on the same edge that takes the command
`default_nettype none
module pgw_host_model
    import pgw_pkg::*;
(
    // clock
    input  wire logic      clk,
    // command port
    output var pgw_cmd_s   cmd,
    input  wire pgw_rsp_s  rsp,
    // side effects seen with the answer
    input  wire pgw_chwr_s chwr,
    input  wire logic      log_restore,
    input  wire logic      log_clear
);
    timeunit 1ns;
    timeprecision 1ns;

    initial cmd = '0;

    // released code and data carry inverted junk; kind keeps the last value
    task automatic xfer(input pgw_kind_e k, input logic [7:0] c, input logic [15:0] d,
                        output pgw_rsp_s r, output pgw_chwr_s w, output logic [1:0] p);
        @(posedge clk);
        cmd <= '{valid: 1'b1, kind: k, code: c, data: d};
        @(posedge clk);
        cmd <= '{valid: 1'b0, kind: k, code: ~c, data: ~d};
        #1;
        r = rsp;
        w = chwr;
        p = {log_restore, log_clear};
    endtask
endmodule
`default_nettype wire

// [verification/pgw_page_write_guard_bench.sv]
// self-checking bench for the page and write guard
// assumes a zero-latency fault record ram modelled here
`default_nettype none
`include "pgw_regs.svh"
module pgw_page_write_guard_bench
    import pgw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       clk, rstn, wp_pin, nv_wp_load, log_restore, log_clear, cml_fault;
    logic [7:0] nv_wp_value, log_addr, log_byte, wp_setting, retry_limit, bcast_mask, chsel;
    pgw_cmd_s   cmd;
    pgw_rsp_s   rsp, r;
    pgw_chwr_s  chwr, w;
    pgw_tel_s   tel;
    logic [1:0] p;
    int         mismatches, checks_done;
    logic [7:0] codes [3] = '{`PGW_CMD_OPERATION, `PGW_CMD_ON_OFF, `PGW_CMD_CLEAR};

    // record ram with no latency
    assign log_byte = log_addr ^ 8'h5a;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    pgw_page_write_guard dut (.clk(clk), .rstn(rstn), .cmd(cmd), .rsp(rsp), .wp_pin(wp_pin),
        .nv_wp_load(nv_wp_load), .nv_wp_value(nv_wp_value), .wp_setting(wp_setting),
        .chwr(chwr), .log_restore(log_restore), .log_clear(log_clear), .log_addr(log_addr),
        .log_byte(log_byte), .log_state(8'h3c), .family_flags(8'hc3), .tel(tel),
        .retry_limit(retry_limit), .bcast_mask(bcast_mask), .channel_select(chsel),
        .cml_fault(cml_fault));

    pgw_host_model host (.clk(clk), .cmd(cmd), .rsp(rsp), .chwr(chwr),
        .log_restore(log_restore), .log_clear(log_clear));

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input pgw_kind_e k, input logic [7:0] c, input logic [15:0] d,
                      input logic e);
        host.xfer(k, c, d, r, w, p);
        chk({r.ack, r.err}, {1'b1, e});
    endtask

    task automatic rd(input pgw_kind_e k, input logic [7:0] c, input logic [15:0] d,
                      input logic e);
        host.xfer(k, c, 16'h0000, r, w, p);
        chk({r.ack, r.err, r.data}, {1'b1, e, d});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        wp_pin = 1'b0;
        nv_wp_load = 1'b0;
        nv_wp_value = 8'h00;
        tel.vin_min = 16'hd280;
        tel.temp_min = 16'he9a0;
        for (int i = 0; i < 8; i++)
            tel.vout_min[i] = 16'h1000 + 16'(i);
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk({retry_limit, bcast_mask, chsel, wp_setting, cml_fault},
            {`PGW_RETRY_RST, `PGW_MASK_RST, `PGW_PAGE_RST, `PGW_WP_RST, 1'b0});
        chk({rsp.ack, chwr.valid, log_restore, log_clear, log_addr}, 12'h000);
        for (int pg = 0; pg < 8; pg++) begin
            wr(PGW_WR_BYTE, `PGW_CMD_PAGE, 16'(pg), 1'b0);
            wr(PGW_WR_BYTE, `PGW_CMD_OPERATION, 16'h0080, 1'b0);
            chk({w.valid, w.mask, w.code, w.data},
                {1'b1, 8'(1 << pg), `PGW_CMD_OPERATION, 16'h0080});
        end
        wr(PGW_WR_BYTE, `PGW_CMD_PAGE, 16'h0008, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_OPERATION, 16'h0080, 1'b0);
        chk(w.mask, 8'h00);
        chk(chsel, 8'h08);
        wr(PGW_WR_BYTE, `PGW_CMD_MASK, 16'h005a, 1'b0);
        chk(bcast_mask, 8'h5a);
        wr(PGW_WR_BYTE, `PGW_CMD_PAGE, 16'h00ff, 1'b0);
        foreach (codes[i]) begin
            wr((codes[i] == `PGW_CMD_CLEAR) ? PGW_SEND : PGW_WR_BYTE, codes[i], 16'h0040, 1'b0);
            chk({w.valid, w.mask, w.code}, {1'b1, 8'h5a, codes[i]});
        end
        wr(PGW_WR_BYTE, 8'hd2, 16'h0001, 1'b1);
        chk({w.valid, cml_fault}, 2'b01);
        wr(PGW_SEND, `PGW_CMD_CLEAR, 16'h0000, 1'b0);
        chk(cml_fault, 1'b0);
        rd(PGW_RD_WORD, `PGW_CMD_VOUT_MIN, 16'h0000, 1'b1);
        chk(cml_fault, 1'b1);
        wr(PGW_SEND, `PGW_CMD_CLEAR, 16'h0000, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_PAGE, 16'h0002, 1'b0);
        rd(PGW_RD_WORD, `PGW_CMD_VOUT_MIN, 16'h1002, 1'b0);
        chk(r.fmt, PGW_FMT_UV);
        rd(PGW_RD_WORD, `PGW_CMD_VIN_MIN, 16'hd280, 1'b0);
        chk(r.fmt, PGW_FMT_SL);
        rd(PGW_RD_WORD, `PGW_CMD_TEMP_MIN, 16'he9a0, 1'b0);
        rd(PGW_RD_BYTE, `PGW_CMD_LOG_STATE, 16'h003c, 1'b0);
        rd(PGW_RD_BYTE, `PGW_CMD_FAMILY, 16'h00c3, 1'b0);
        chk(r.fmt, PGW_FMT_REG);
        wr(PGW_WR_BYTE, `PGW_CMD_RETRY, 16'h0003, 1'b0);
        chk(retry_limit, 8'h03);
        rd(PGW_RD_BYTE, `PGW_CMD_RETRY, 16'h0003, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_WP, 16'h0080, 1'b0);
        chk(wp_setting, 8'h80);
        wr(PGW_WR_BYTE, `PGW_CMD_RETRY, 16'h0005, 1'b1);
        chk(cml_fault, 1'b1);
        rd(PGW_RD_BYTE, `PGW_CMD_RETRY, 16'h0003, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_OPERATION, 16'h0080, 1'b1);
        wr(PGW_WR_BYTE, `PGW_CMD_WP, 16'h0040, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_OPERATION, 16'h0080, 1'b0);
        chk(w.valid, 1'b1);
        wr(PGW_WR_BYTE, `PGW_CMD_RETRY, 16'h0005, 1'b1);
        wr(PGW_SEND, `PGW_CMD_CLEAR, 16'h0000, 1'b0);
        chk(cml_fault, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_WP, 16'h0000, 1'b0);
        wp_pin <= 1'b1;
        repeat (3) @(posedge clk);
        wr(PGW_WR_BYTE, `PGW_CMD_RETRY, 16'h0009, 1'b1);
        wr(PGW_WR_BYTE, `PGW_CMD_WP, 16'h0080, 1'b0);
        wr(PGW_WR_BYTE, `PGW_CMD_OPERATION, 16'h0080, 1'b1);
        wp_pin <= 1'b0;
        @(posedge clk);
        nv_wp_value <= 8'h40;
        nv_wp_load <= 1'b1;
        @(posedge clk);
        nv_wp_load <= 1'b0;
        #1;
        chk(wp_setting, 8'h40);
        wr(PGW_WR_BYTE, `PGW_CMD_WP, 16'h0000, 1'b0);
        wr(PGW_SEND, `PGW_CMD_LOG_RESTORE, 16'h0000, 1'b0);
        chk(p, 2'b10);
        wr(PGW_SEND, `PGW_CMD_LOG_CLEAR, 16'h0000, 1'b0);
        chk(p, 2'b01);
        rd(PGW_RD_BLK_FIRST, `PGW_CMD_LOG_STREAM, 16'h00ff, 1'b0);
        for (int k = 1; k < 256; k++)
            rd(PGW_RD_BLK_NEXT, `PGW_CMD_LOG_STREAM, {8'h00, 8'(k - 1) ^ 8'h5a}, 1'b0);
        host.xfer(PGW_RD_BLK_NEXT, `PGW_CMD_LOG_STREAM, 16'h0000, r, w, p);
        chk({r.ack, r.err}, 2'b11);
        wrap_up();
    end
endmodule
`default_nettype wire
